// File: pav_pkg.sv
// pav_pkg: constants and types for the program address and comparator irq block
// assumes a single core clock domain and an 8-bit register port
package pav_pkg;

  // widths
  localparam int PC_W = 13;
  localparam int WORD_W = 14;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // fixed vectors and counter step
  localparam logic [12:0] VEC_RESET = 13'h0000;
  localparam logic [12:0] VEC_IRQ = 13'h0004;
  localparam logic [12:0] PC_STEP = 13'h0001;

  // implemented store sizes as address widths: 512, 1K, 2K words
  localparam int AW_512 = 9;
  localparam int AW_1K = 10;
  localparam int AW_2K = 11;

  // register offsets
  localparam logic [7:0] OFF_IRQ_FLAG = 8'h0C;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h8C;
  localparam logic [7:0] OFF_IRQ_CONTROL = 8'h0B;

  // field positions
  localparam int BIT_CMP = 6;
  localparam int BIT_GIE = 7;

  // register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pav_bus_s;

  // core fetch sequencing request
  typedef struct packed {
    logic irq_take;
    logic load;
    logic inc;
    logic [12:0] target;
  } pav_fetch_s;

  // whole state of the block
  typedef struct packed {
    logic [12:0] pc;
    logic cmp_en;
    logic cmp_flag;
    logic global_irq_enable;
    logic irq;
    logic sync1;
    logic sync2;
    logic sync3;
    logic [7:0] rdata;
  } pav_state_s;

  localparam pav_state_s STATE_RESET = '{
    pc: VEC_RESET,
    cmp_en: 1'b0,
    cmp_flag: 1'b0,
    global_irq_enable: 1'b0,
    irq: 1'b0,
    sync1: 1'b0,
    sync2: 1'b0,
    sync3: 1'b0,
    rdata: 8'h00
  };

endpackage

// File: pav_addr_irq.sv
// pav_addr_irq: program counter with wrapped store address, vectors and comparator irq
// assumes the core drives fetch requests and register strobes on mclk_i;
// cmp_i is an asynchronous level from the comparator
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module pav_addr_irq #(
  parameter int IMPL_AW = pav_pkg::AW_2K
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire pav_pkg::pav_bus_s bus_i,
  output logic [7:0] rdata_o,
  input wire pav_pkg::pav_fetch_s fetch_i,
  output logic [12:0] pc_o,
  output logic [IMPL_AW-1:0] rom_addr_o,
  input wire logic cmp_i,
  output logic irq_o
);

  pav_pkg::pav_state_s q;
  pav_pkg::pav_state_s d;
  logic cmp_change;

  // next state of the whole block
  always_comb begin
    d = q;
    // comparator level synchroniser and edge history
    d.sync1 = cmp_i;
    d.sync2 = q.sync1;
    d.sync3 = q.sync2;
    cmp_change = q.sync2 ^ q.sync3;
    // program counter sequencing, irq vector first
    if (fetch_i.irq_take) begin
      d.pc = pav_pkg::VEC_IRQ;
    end else if (fetch_i.load) begin
      d.pc = fetch_i.target;
    end else if (fetch_i.inc) begin
      d.pc = q.pc + pav_pkg::PC_STEP;
    end
    // register writes
    if (bus_i.wr) begin
      unique case (bus_i.addr)
        pav_pkg::OFF_IRQ_ENABLE: begin
          d.cmp_en = bus_i.wdata[pav_pkg::BIT_CMP];
        end
        pav_pkg::OFF_IRQ_CONTROL: begin
          d.global_irq_enable = bus_i.wdata[pav_pkg::BIT_GIE];
        end
        pav_pkg::OFF_IRQ_FLAG: begin
          if (bus_i.wdata[pav_pkg::BIT_CMP]) begin
            d.cmp_flag = 1'b0; // write one clears
          end
        end
        default: begin
        end
      endcase
    end
    // a change in the clearing cycle still sets the flag
    if (cmp_change) begin
      d.cmp_flag = 1'b1;
    end
    // read data, one cycle after the strobe, unmapped reads zero
    d.rdata = 8'h00;
    if (bus_i.rd) begin
      unique case (bus_i.addr)
        pav_pkg::OFF_IRQ_ENABLE: begin
          d.rdata[pav_pkg::BIT_CMP] = q.cmp_en;
        end
        pav_pkg::OFF_IRQ_FLAG: begin
          d.rdata[pav_pkg::BIT_CMP] = q.cmp_flag;
        end
        pav_pkg::OFF_IRQ_CONTROL: begin
          d.rdata[pav_pkg::BIT_GIE] = q.global_irq_enable;
        end
        default: begin
        end
      endcase
    end
    // level request to the core
    d.irq = d.cmp_flag & d.cmp_en & d.global_irq_enable;
  end

  // state register, synchronous reset
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      q <= pav_pkg::STATE_RESET;
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state register
  assign pc_o = q.pc;
  assign rom_addr_o = q.pc[IMPL_AW-1:0];
  assign rdata_o = q.rdata;
  assign irq_o = q.irq;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  // counter starts at zero after reset
  a_reset_fetch_zero: assert property (disable iff (1'b0) !rst_n_i |=> pc_o == 13'h0000)
    else $error("pc not zero after reset");

  // enable bit clear after reset
  a_enable_reset_zero: assert property (disable iff (1'b0) !rst_n_i |=> !q.cmp_en)
    else $error("comparator enable not clear after reset");

  // interrupt taken loads the vector
  a_irq_vector_load: assert property (fetch_i.irq_take |=> pc_o == 13'h0004)
    else $error("pc not at irq vector after irq take");

  // plain increment steps by one modulo 8K
  a_pc_step_one: assert property (fetch_i.inc && !fetch_i.load && !fetch_i.irq_take
    |=> pc_o == 13'($past(pc_o) + 13'h0001))
    else $error("pc did not step by one");

  // store address is the low counter bits
  a_rom_addr_wrap: assert property (rom_addr_o == pc_o[IMPL_AW-1:0] && IMPL_AW <= 11)
    else $error("store address does not wrap");

  // enable write takes bit 6 only
  a_enable_write_bit: assert property (bus_i.wr && bus_i.addr == 8'h8C
    |=> q.cmp_en == $past(bus_i.wdata[6]))
    else $error("enable bit write not taken");

  // enable read shows bit 6, zeros elsewhere
  a_enable_read_back: assert property (bus_i.rd && bus_i.addr == 8'h8C
    |=> rdata_o == {1'b0, $past(q.cmp_en), 6'b000000})
    else $error("enable register read wrong");

  // flag read shows bit 6, zeros elsewhere
  a_flag_read_back: assert property (bus_i.rd && bus_i.addr == 8'h0C
    |=> rdata_o == {1'b0, $past(q.cmp_flag), 6'b000000})
    else $error("flag register read wrong");

  // comparator change sets the flag whatever the enables
  a_flag_on_change: assert property ($changed(q.sync2) ##1 1'b1 |-> q.cmp_flag)
    else $error("flag not set on comparator change");

  // request level follows the three-way and
  a_irq_gating: assert property (irq_o == (q.cmp_flag && q.cmp_en && q.global_irq_enable))
    else $error("irq request not gated by flag and enables");

  // read data stands one cycle only, zero when no read was made
  a_rdata_idle_zero: assert property (!bus_i.rd |=> rdata_o == 8'h00)
    else $error("read data not zero without a read strobe");

  // jump loads the target when no interrupt is taken
  a_load_target: assert property (fetch_i.load && !fetch_i.irq_take
    |=> pc_o == $past(fetch_i.target))
    else $error("pc did not take the jump target");

  // writing one clears the flag when no change arrives in that cycle
  a_flag_clear_write: assert property (bus_i.wr && bus_i.addr == 8'h0C && bus_i.wdata[6]
    && q.sync2 == q.sync3 |=> !q.cmp_flag)
    else $error("flag not cleared by write one");

  // flag holds unless software clears it
  a_flag_sticky: assert property (q.cmp_flag && !(bus_i.wr && bus_i.addr == 8'h0C)
    |=> q.cmp_flag)
    else $error("flag dropped without a clear");

  // a clear enable blocks the request unless a write sets it in that cycle
  a_irq_blocked_disabled: assert property (!q.cmp_en |=> !irq_o)
    else $error("irq request raised with enable clear");

endmodule // pav_addr_irq

`default_nettype wire

// File: pav_core_model.sv
// pav_core_model: core fetch and interrupt sequencing seen from the block
// assumes the bench asks for inc or load one cycle ahead, on mclk_i
`timescale 1ns/1ps
`default_nettype none
module pav_core_model (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic inc_i,
  input wire logic load_i,
  input wire logic [12:0] target_i,
  input wire logic irq_i,
  input wire logic take_en_i,
  output pav_pkg::pav_fetch_s fetch_o
);
  // one request per cycle, interrupt taken on a one-cycle pulse
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      fetch_o <= '0;
    end else begin
      fetch_o.irq_take <= irq_i && take_en_i && !fetch_o.irq_take;
      fetch_o.load <= load_i;
      fetch_o.inc <= inc_i;
      fetch_o.target <= target_i;
    end
  end
endmodule // pav_core_model
`default_nettype wire

// File: pav_addr_irq_tb.sv
// pav_addr_irq_tb: register, fetch and comparator irq tests
// assumes a 512-word store so high counter bits wrap early
`timescale 1ns/1ps
`default_nettype none
`define CHK(a,b) begin check_count++; if ((a)!==(b)) begin errors++; \
  $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module pav_addr_irq_tb;
  logic mclk_i = 0, rst_n_i = 0, cmp_i = 0, inc = 0, load = 0, take_en = 0, irq_o;
  logic [12:0] target = '0, pc_o;
  logic [8:0] rom_addr_o;
  logic [7:0] rdata_o;
  int errors = 0, check_count = 0;
  pav_pkg::pav_bus_s bus = '0;
  pav_pkg::pav_fetch_s fetch;
  always #12.5 mclk_i = ~mclk_i;
  pav_addr_irq #(.IMPL_AW(9)) pav_addr_irq_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .bus_i(bus), .rdata_o(rdata_o), .fetch_i(fetch), .pc_o(pc_o),
    .rom_addr_o(rom_addr_o), .cmp_i(cmp_i), .irq_o(irq_o));
  pav_core_model pav_core_model_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .inc_i(inc),
    .load_i(load), .target_i(target), .irq_i(irq_o), .take_en_i(take_en), .fetch_o(fetch));
  // one-cycle register write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i) begin bus.wr <= 1; bus.addr <= a; bus.wdata <= d; end
    @(posedge mclk_i) bus.wr <= 0;
  endtask
  // one-cycle read, data checked in the following cycle
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk_i) begin bus.rd <= 1; bus.addr <= a; end
    @(posedge mclk_i) bus.rd <= 0;
    #1 `CHK(rdata_o, e)
  endtask
  // comparator toggle, flag lands three edges later
  task automatic flip();
    @(posedge mclk_i) cmp_i <= ~cmp_i;
    repeat (5) @(posedge mclk_i);
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge mclk_i);
    errors++;
    test_done();
  end
  initial begin
    repeat (12) @(posedge mclk_i);
    rst_n_i <= 1;
    #1 `CHK(pc_o, 13'h0000)
    rd(8'h8C, 8'h00);
    $display("test reset done");
    wr(8'h8C, 8'hFF);
    rd(8'h8C, 8'h40);
    wr(8'h8C, 8'h00);
    rd(8'h8C, 8'h00);
    rd(8'h55, 8'h00);
    @(posedge mclk_i);
    #1 `CHK(rdata_o, 8'h00)
    $display("test enable done");
    @(posedge mclk_i) begin load <= 1; target <= 13'h1FFF; end
    @(posedge mclk_i) load <= 0;
    repeat (2) @(posedge mclk_i);
    #1 `CHK({pc_o, rom_addr_o}, {13'h1FFF, 9'h1FF})
    @(posedge mclk_i) inc <= 1;
    @(posedge mclk_i) inc <= 0;
    repeat (2) @(posedge mclk_i);
    #1 `CHK(pc_o, 13'h0000)
    $display("test fetch done");
    flip();
    #1 `CHK(irq_o, 1'b0)
    rd(8'h0C, 8'h40);
    wr(8'h0C, 8'h40);
    rd(8'h0C, 8'h00);
    $display("test flag done");
    wr(8'h0B, 8'h80);
    rd(8'h0B, 8'h80);
    wr(8'h8C, 8'h40);
    #1 `CHK(irq_o, 1'b0)
    @(posedge mclk_i) take_en <= 1;
    flip();
    repeat (3) @(posedge mclk_i);
    #1 `CHK({irq_o, pc_o}, {1'b1, 13'h0004})
    wr(8'h8C, 8'h00);
    #1 `CHK(irq_o, 1'b0)
    $display("test irq done");
    test_done();
  end
endmodule // pav_addr_irq_tb
`default_nettype wire
